// file: hdl/tdmfc_tally.sv
// Free running 24-bit frame counter for one direction.
`timescale 1ns/1ps
`default_nettype none
module tdmfc_tally #(
   parameter int WIDTH = 24
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Frame start pulse and count.
   input wire logic frame_start,
   output logic [WIDTH-1:0] count
);
   import tdmfc_pkg::*;
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   // ==========================================================================
   // Count frame starts, wrapping naturally from all ones to zero.
   always_comb begin
      count_next = count_reg;
      if (frame_start) begin
         count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   // Register the count; reset clears it.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_reg <= WIDTH'(TDMFC_TALLY_RST);
      end else begin
         count_reg <= count_next;
      end
   end
   assign count = count_reg;
endmodule : tdmfc_tally
`default_nettype wire

// file: hdl/tdmfc_top.sv
// Register bank for transfer enable, receive frame length and frame tallies over classic Wishbone.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Rx frame length bits 6:0 mean n+1 slots
// - Rx frame length resets to 0x7F
// - Rx frame length writes ignored while receive runs
// - Enable bit 0 runs both units, resets 0
// - Read-only 24-bit tx tally, resets zero
// - Read-only 24-bit rx tally, resets zero
module tdmfc_top #(
   parameter int TALLY_W = 24
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tdmfc_pkg::TDMFC_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Frame starts from the serial side.
   input wire logic tx_frame_start,
   input wire logic rx_frame_start,
   // Control outputs.
   output logic transfer_units_enable,
   output logic [tdmfc_pkg::TDMFC_FLEN_W-1:0] rx_frame_length,
   output logic rx_serial_enable
);
   import tdmfc_pkg::*;
   // Bus answer state and registered read data.
   tdmfc_bus_state_t state_reg, state_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   // Software visible control fields.
   logic enable_reg, enable_next;
   logic [TDMFC_FLEN_W-1:0] flen_reg, flen_next;
   logic rx_run_reg, rx_run_next;
   // Frame tallies from the two counters.
   logic [TALLY_W-1:0] tx_count;
   logic [TALLY_W-1:0] rx_count;
   // Request taken this cycle, and whether it writes.
   logic req;
   logic wr;
   // ==========================================================================
   // Frame tallies.
   tdmfc_tally #(.WIDTH(TALLY_W)) u_tx_tally (
      .ref_clk(ref_clk),
      .rst(rst),
      .frame_start(tx_frame_start),
      .count(tx_count)
   );
   tdmfc_tally #(.WIDTH(TALLY_W)) u_rx_tally (
      .ref_clk(ref_clk),
      .rst(rst),
      .frame_start(rx_frame_start),
      .count(rx_count)
   );
   // ==========================================================================
   // Bus decode: one answer per request, ack falls the cycle after.
   // A request is taken only while idle, so a master still holding cyc and stb in the ack cycle is not
   // answered twice. Writes land at the taking edge; read data is the value from before that edge.
   assign req = wb_cyc_i && wb_stb_i && (state_reg == TDMFC_IDLE);
   assign wr = req && wb_we_i;
   always_comb begin
      // Defaults: hold every field and give no answer.
      state_next = TDMFC_IDLE;
      ack_next = 1'b0;
      dat_next = dat_reg;
      enable_next = enable_reg;
      flen_next = flen_reg;
      rx_run_next = rx_run_reg;
      if (req) begin
         state_next = TDMFC_ACKED;
         ack_next = 1'b1;
         dat_next = TDMFC_ZERO;
         unique case (wb_adr_i)
            TDMFC_XFER_CTRL_OFS: begin
               dat_next[TDMFC_ENABLE_BIT] = enable_reg;
               if (wr && wb_sel_i[0]) begin
                  enable_next = wb_dat_i[TDMFC_ENABLE_BIT];
               end
            end
            TDMFC_TX_TALLY_OFS: begin
               dat_next[TALLY_W-1:0] = tx_count;
            end
            TDMFC_RX_TALLY_OFS: begin
               dat_next[TALLY_W-1:0] = rx_count;
            end
            TDMFC_RX_GEOM_OFS: begin
               dat_next[TDMFC_FLEN_W-1:0] = flen_reg;
               if (wr && wb_sel_i[0] && !rx_run_reg) begin
                  flen_next = wb_dat_i[TDMFC_FLEN_W-1:0];
               end
            end
            TDMFC_SERIAL_CTRL_OFS: begin
               dat_next[TDMFC_RX_RUN_BIT] = rx_run_reg;
               if (wr && wb_sel_i[0]) begin
                  rx_run_next = wb_dat_i[TDMFC_RX_RUN_BIT];
               end
            end
            default: begin
               dat_next = TDMFC_ZERO;
            end
         endcase
      end
   end
   // Register bus and control state.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= TDMFC_IDLE;
         ack_reg <= 1'b0;
         dat_reg <= TDMFC_ZERO;
         enable_reg <= TDMFC_ENABLE_RST;
         flen_reg <= TDMFC_FLEN_RST;
         rx_run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         enable_reg <= enable_next;
         flen_reg <= flen_next;
         rx_run_reg <= rx_run_next;
      end
   end
   // Every output comes straight from a register.
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign transfer_units_enable = enable_reg;
   assign rx_frame_length = flen_reg;
   assign rx_serial_enable = rx_run_reg;
   // ==========================================================================
   // Checks on the frame length, enable and frame tally fields.
   // Each property names its own clock; reset disables all but the two reset checks, which look back at it.
   property p_flen_reset;
      @(posedge ref_clk) $past(rst) |-> flen_reg == TDMFC_FLEN_RST;
   endproperty
   a_flen_reset: assert property (p_flen_reset) else $error("Frame length reset wrong.");
   property p_flen_protect;
      @(posedge ref_clk) disable iff (rst) rx_run_reg |=> flen_reg == $past(flen_reg);
   endproperty
   a_flen_protect: assert property (p_flen_protect) else $error("Frame length changed while receive ran.");
   property p_flen_write;
      @(posedge ref_clk) disable iff (rst)
         wr && wb_adr_i == TDMFC_RX_GEOM_OFS && wb_sel_i[0] && !rx_run_reg
         |=> flen_reg == $past(wb_dat_i[TDMFC_FLEN_W-1:0]);
   endproperty
   a_flen_write: assert property (p_flen_write) else $error("Frame length write lost.");
   property p_enable;
      @(posedge ref_clk) disable iff (rst)
         wr && wb_adr_i == TDMFC_XFER_CTRL_OFS && wb_sel_i[0] |=> transfer_units_enable == $past(wb_dat_i[0]);
   endproperty
   a_enable: assert property (p_enable) else $error("Enable write not applied.");
   property p_enable_reset;
      @(posedge ref_clk) $past(rst) |-> !transfer_units_enable;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("Enable not cleared by reset.");
   property p_tx_count;
      @(posedge ref_clk) disable iff (rst) tx_frame_start && !$past(rst) |=> tx_count == $past(tx_count) + 24'h000001;
   endproperty
   a_tx_count: assert property (p_tx_count) else $error("Transmit tally did not step.");
   property p_rx_hold;
      @(posedge ref_clk) disable iff (rst) !rx_frame_start |=> rx_count == $past(rx_count);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("Receive tally moved without a frame.");
   property p_tally_read;
      @(posedge ref_clk) disable iff (rst)
         req && wb_adr_i == TDMFC_RX_TALLY_OFS |=> wb_ack_o && wb_dat_o[31:24] == 8'h00 ##1 !wb_ack_o;
   endproperty
   a_tally_read: assert property (p_tally_read) else $error("Tally read answer wrong.");
   // Enable holds unless software writes the control register with lane 0.
   property p_enable_hold;
      @(posedge ref_clk) disable iff (rst)
         !(wr && wb_adr_i == TDMFC_XFER_CTRL_OFS && wb_sel_i[0]) |=> $stable(transfer_units_enable);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("Enable moved without a write.");
   // ==========================================================================
   // Checks on read answers.
   // Control read shows the enable bit alone; reserved bits stay zero.
   property p_ctrl_read;
      @(posedge ref_clk) disable iff (rst)
         req && wb_adr_i == TDMFC_XFER_CTRL_OFS |=> wb_dat_o == {31'h00000000, $past(enable_reg)};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("Control read answer wrong.");
   // Geometry read shows the frame length in the low bits and zeros above.
   property p_geom_read;
      @(posedge ref_clk) disable iff (rst)
         req && wb_adr_i == TDMFC_RX_GEOM_OFS |=> wb_dat_o == 32'($past(flen_reg));
   endproperty
   a_geom_read: assert property (p_geom_read) else $error("Geometry read answer wrong.");
   // Transmit tally read returns the count from the taking edge, upper bits zero.
   property p_tx_read;
      @(posedge ref_clk) disable iff (rst)
         req && wb_adr_i == TDMFC_TX_TALLY_OFS |=> wb_dat_o == 32'($past(tx_count));
   endproperty
   a_tx_read: assert property (p_tx_read) else $error("Transmit tally read answer wrong.");
   // Receive tally read returns the count from the taking edge, upper bits zero.
   property p_rx_read;
      @(posedge ref_clk) disable iff (rst)
         req && wb_adr_i == TDMFC_RX_TALLY_OFS |=> wb_dat_o == 32'($past(rx_count));
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("Receive tally read answer wrong.");
   // ==========================================================================
   // Checks on the frame tallies.
   // Transmit tally holds between frame starts.
   property p_tx_hold;
      @(posedge ref_clk) disable iff (rst) !tx_frame_start |=> tx_count == $past(tx_count);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("Transmit tally moved without a frame.");
   // Receive tally steps by one on each frame start, wrapping from all ones.
   property p_rx_count;
      @(posedge ref_clk) disable iff (rst) rx_frame_start |=> rx_count == $past(rx_count) + {{(TALLY_W-1){1'b0}}, 1'b1};
   endproperty
   a_rx_count: assert property (p_rx_count) else $error("Receive tally did not step.");
   // Main scenarios worth seeing in a run.
   c_write_en: cover property (@(posedge ref_clk) wr && wb_adr_i == TDMFC_XFER_CTRL_OFS);
   c_read_rx_tally: cover property (@(posedge ref_clk) req && wb_adr_i == TDMFC_RX_TALLY_OFS);
   c_flen_applied: cover property (@(posedge ref_clk) wr && wb_adr_i == TDMFC_RX_GEOM_OFS && !rx_run_reg);
   c_blocked: cover property (@(posedge ref_clk) wr && wb_adr_i == TDMFC_RX_GEOM_OFS && rx_run_reg);
   c_wrap: cover property (@(posedge ref_clk) rx_frame_start && &rx_count);
endmodule : tdmfc_top
`default_nettype wire

// file: inc/tdmfc_pkg.sv
// Package of register map, field layout and reset values for the transfer enable and frame tally bank.
`default_nettype none
package tdmfc_pkg;
   // ==========================================================================
   // Register byte offsets.
   localparam logic [9:0] TDMFC_XFER_CTRL_OFS = 10'h0c0;
   localparam logic [9:0] TDMFC_TX_TALLY_OFS = 10'h104;
   localparam logic [9:0] TDMFC_RX_TALLY_OFS = 10'h108;
   localparam logic [9:0] TDMFC_RX_GEOM_OFS = 10'h10c;
   localparam logic [9:0] TDMFC_SERIAL_CTRL_OFS = 10'h110;
   localparam int TDMFC_ADDR_W = 10;
   // ==========================================================================
   // Field layout and reset values.
   localparam int TDMFC_FLEN_W = 7;
   localparam logic [6:0] TDMFC_FLEN_RST = 7'h7f;
   localparam int TDMFC_TALLY_W = 24;
   localparam logic [23:0] TDMFC_TALLY_RST = 24'h000000;
   localparam logic TDMFC_ENABLE_RST = 1'h0;
   localparam int TDMFC_ENABLE_BIT = 0;
   localparam int TDMFC_RX_RUN_BIT = 0;
   localparam logic [31:0] TDMFC_ZERO = 32'h00000000;
   // Bus answer states.
   typedef enum logic [0:0] {TDMFC_IDLE, TDMFC_ACKED} tdmfc_bus_state_t;
endpackage : tdmfc_pkg
`default_nettype wire

// file: verification/tdmfc_top_bench.sv
// Self-checking bench for the transfer enable and frame tally register bank.
`timescale 1ns/1ps
`default_nettype none
module tdmfc_top_bench;
   import tdmfc_pkg::*;
   // ==========================================================================
   // Stimulus and observed signals.
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic txs = 1'h0;
   logic rxs = 1'h0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic ack;
   logic en;
   logic run;
   logic [6:0] flen;
   int num_errors = 0;
   int n_compared = 0;
   // The block under test.
   tdmfc_top i_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .tx_frame_start(txs),
      .rx_frame_start(rxs), .transfer_units_enable(en), .rx_frame_length(flen), .rx_serial_enable(run));
   // Clock of 20 ns period.
   always #10 ref_clk = ~ref_clk;
   // ==========================================================================
   // Compares one value and counts it.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One classic cycle; the request holds until ack is sampled high, then idles a cycle.
   // The wait has no limit of its own: the watchdog ends a hung handshake.
   task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge ref_clk);
      while (ack !== 1'h1) begin
         @(posedge ref_clk);
      end
      rdat = dat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge ref_clk);
      chk("ack drop", 32'h0, {31'h0, ack});
   endtask : bus
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      bus(1'h1, a, 4'hf, d);
   endtask : wr
   // Reads a register and compares the word.
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      bus(1'h0, a, 4'hf, 32'h00000000);
      chk($sformatf("reg %h", a), exp, rdat);
   endtask : rdc
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // Watchdog against a hung handshake.
   initial begin
      #200000;
      num_errors++;
      results();
   end
   // ==========================================================================
   // Test sequence.
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      @(posedge ref_clk);
      chk("enable", 32'h0, {31'h0, en});
      chk("length", 32'h7f, {25'h0, flen});
      rdc(TDMFC_XFER_CTRL_OFS, 32'h0);
      rdc(TDMFC_TX_TALLY_OFS, 32'h0);
      rdc(TDMFC_RX_TALLY_OFS, 32'h0);
      rdc(TDMFC_RX_GEOM_OFS, 32'h7f);
      $display("reset values done");
      wr(TDMFC_XFER_CTRL_OFS, 32'hffffffff);
      rdc(TDMFC_XFER_CTRL_OFS, 32'h1);
      chk("enable", 32'h1, {31'h0, en});
      wr(TDMFC_XFER_CTRL_OFS, 32'hfffffffe);
      rdc(TDMFC_XFER_CTRL_OFS, 32'h0);
      chk("enable", 32'h0, {31'h0, en});
      $display("enable bit done");
      wr(TDMFC_RX_GEOM_OFS, 32'h05);
      rdc(TDMFC_RX_GEOM_OFS, 32'h05);
      chk("length", 32'h05, {25'h0, flen});
      bus(1'h1, TDMFC_RX_GEOM_OFS, 4'he, 32'h6a);
      rdc(TDMFC_RX_GEOM_OFS, 32'h05);
      wr(TDMFC_SERIAL_CTRL_OFS, 32'h1);
      chk("rx run", 32'h1, {31'h0, run});
      wr(TDMFC_RX_GEOM_OFS, 32'h33);
      rdc(TDMFC_RX_GEOM_OFS, 32'h05);
      chk("length", 32'h05, {25'h0, flen});
      wr(TDMFC_SERIAL_CTRL_OFS, 32'h0);
      wr(TDMFC_RX_GEOM_OFS, 32'hffffffff);
      rdc(TDMFC_RX_GEOM_OFS, 32'h7f);
      $display("frame length done");
      for (int i = 0; i < 3; i++) begin
         txs <= 1'h1;
         rxs <= (i < 2);
         @(posedge ref_clk);
         txs <= 1'h0;
         rxs <= 1'h0;
         @(posedge ref_clk);
      end
      rdc(TDMFC_TX_TALLY_OFS, 32'h3);
      rdc(TDMFC_RX_TALLY_OFS, 32'h2);
      wr(TDMFC_TX_TALLY_OFS, 32'hffffffff);
      wr(TDMFC_RX_TALLY_OFS, 32'hffffffff);
      rdc(TDMFC_TX_TALLY_OFS, 32'h3);
      rdc(TDMFC_RX_TALLY_OFS, 32'h2);
      wr(10'h3fc, 32'hffffffff);
      rdc(10'h3fc, 32'h0);
      $display("tallies done");
      // Load values away from reset, then reset in mid-run and see every field come back.
      wr(TDMFC_XFER_CTRL_OFS, 32'h1);
      wr(TDMFC_RX_GEOM_OFS, 32'h12);
      wr(TDMFC_SERIAL_CTRL_OFS, 32'h1);
      rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      @(posedge ref_clk);
      chk("enable", 32'h0, {31'h0, en});
      chk("length", 32'h7f, {25'h0, flen});
      chk("rx run", 32'h0, {31'h0, run});
      rdc(TDMFC_TX_TALLY_OFS, 32'h0);
      rdc(TDMFC_RX_TALLY_OFS, 32'h0);
      $display("mid-run reset done");
      results();
   end
endmodule : tdmfc_top_bench
`default_nettype wire
